/* core/adcc_fifo.sv */
// Output word FIFO module is kept in adcc_top.sv beside the rest of the logic

/* core/adcc_pkg.sv */
// Package of constants and types for the converter control block
// Functional notes
// - One conversion started every sample clock
// - Stabilizer tolerates 20 to 80 percent duty
// - Sleep request high suspends conversions
// - Sleep makes output undefined, pipeline lost
// - Four-level select picks format and stabilizer
// - Words after select change may be wrong
// - Result presented as 14-bit parallel word
// - Output valid only while sleep request low
// - Two's complement is offset binary, MSB inverted
package adcc_pkg;
    // ----------------------------------------
    // Sizes and timing
    // ----------------------------------------
    localparam int DATA_W        = 14;
    localparam int LATENCY       = 7;
    localparam int FIFO_DEPTH    = 32;
    localparam int DUTY_MIN_PCT  = 20;
    localparam int DUTY_MAX_PCT  = 80;
    localparam int MCLK_HZ       = 10_000_000;
    localparam int WAKE_US       = 280;
    localparam int WAKE_CYCLES   = (WAKE_US * (MCLK_HZ / 1_000_000));
    localparam int SETTLE_CYCLES = 4;
    // ----------------------------------------
    // Select level encoding
    // ----------------------------------------
    typedef enum logic [1:0] {
        SEL_SUPPLY,
        SEL_GROUND,
        SEL_MIDREF,
        SEL_FLOAT
    } adcc_sel_e;
    localparam logic [13:0] RESET_WORD = 14'h0000;
endpackage

/* core/adcc_top.sv */
// Converter digital control, output word FIFO and output port
module adcc_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             flush,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two");
    end
    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be positive");
    end
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } adcc_fifo_s;
    adcc_fifo_s       st_reg;
    adcc_fifo_s       st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             doWr;
    logic             doRd;
    // ----------------------------------------
    // Flags and handshake
    // ----------------------------------------
    assign inReady  = (st_reg.wp ^ st_reg.rp) != {1'b1, {AW{1'b0}}};
    assign outValid = st_reg.wp != st_reg.rp;
    assign outData  = mem[st_reg.rp[AW-1:0]];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;
    // ----------------------------------------
    // Pointer update
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        if (flush) begin
            st_next.wp = '0;
            st_next.rp = '0;
        end else begin
            if (doWr) st_next.wp = st_reg.wp + 1'b1;
            if (doRd) st_next.rp = st_reg.rp + 1'b1;
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (doWr && !flush) begin
            mem[st_reg.wp[AW-1:0]] <= inData;
        end
    end
endmodule

module adcc_top #(
    parameter int DATA_W      = adcc_pkg::DATA_W,
    parameter int WAKE_CYCLES = adcc_pkg::WAKE_CYCLES
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // Control pins
    input  wire logic              sleepRequest,
    input  wire logic [1:0]        formatStabilizerSelect,
    // Raw quantizer result
    input  wire logic [DATA_W-1:0] sampleCode,
    // Output port
    output logic      [DATA_W-1:0] outWord,
    output logic                   outValid,
    input  wire logic              outReady,
    output logic                   inFifoReady,
    // Status
    output logic                   stabilizerOn,
    output logic                   twosComplement,
    output logic                   wakeSettling
);
    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    if (DATA_W != adcc_pkg::DATA_W) begin : g_bad_width
        $error("DATA_W must match the output word width");
    end
    if (WAKE_CYCLES < 1) begin : g_bad_wake
        $error("WAKE_CYCLES must be positive");
    end
    if (adcc_pkg::LATENCY < 2 || adcc_pkg::SETTLE_CYCLES > 7) begin : g_bad_pipe
        $error("Pipeline length or settle count out of range");
    end
    localparam int WCW = $clog2(WAKE_CYCLES + 1);
    localparam int L = adcc_pkg::LATENCY;
    typedef enum logic [1:0] { ST_SLEEP, ST_WAKE, ST_RUN } adcc_state_e;
    typedef struct packed {
        logic [2:0]              sleepSync;
        logic [2:0][1:0]         selSync;
        logic                    sleepLvl;
        logic [1:0]              selLvl;
        adcc_state_e             state;
        logic [WCW-1:0]          wakeCnt;
        logic [2:0]              settleCnt;
        logic [L-1:0][DATA_W-1:0] pipe;
        logic [L-1:0]            pipeOk;
        logic [DATA_W-1:0]       word;
        logic                    wordOk;
    } adcc_s;
    adcc_s st_reg;
    adcc_s st_next;
    logic fifoInReady;
    logic fifoOutValid;
    logic [DATA_W-1:0] fifoData;
    logic running;
    logic fmtTwos;
    // ----------------------------------------
    // Select decode
    // ----------------------------------------
    function automatic logic selTwos(input logic [1:0] s);
        return (s == adcc_pkg::SEL_GROUND) || (s == adcc_pkg::SEL_MIDREF);
    endfunction
    function automatic logic selStab(input logic [1:0] s);
        return (s == adcc_pkg::SEL_SUPPLY) || (s == adcc_pkg::SEL_GROUND);
    endfunction
    function automatic logic [DATA_W-1:0] fmtWord(input logic [DATA_W-1:0] code, input logic twos);
        return {code[DATA_W-1] ^ twos, code[DATA_W-2:0]};
    endfunction
    assign fmtTwos = selTwos(st_reg.selLvl);
    assign running = (st_reg.state != ST_SLEEP);
    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.sleepSync = {st_reg.sleepSync[1:0], sleepRequest};
        st_next.selSync   = {st_reg.selSync[1:0], formatStabilizerSelect};
        if (st_reg.sleepSync[2] == st_reg.sleepSync[1]) st_next.sleepLvl = st_reg.sleepSync[2];
        if (st_reg.selSync[2] == st_reg.selSync[1]) st_next.selLvl = st_reg.selSync[2];
        if (st_reg.selLvl != st_next.selLvl) begin
            st_next.settleCnt = 3'(adcc_pkg::SETTLE_CYCLES);
        end else if (st_reg.settleCnt != 3'h0) begin
            st_next.settleCnt = st_reg.settleCnt - 3'h1;
        end
        // ----------------------------------------
        // Wake sequencer
        // ----------------------------------------
        case (st_reg.state)
            ST_SLEEP: begin
                if (!st_reg.sleepLvl) begin
                    st_next.state   = ST_WAKE;
                    st_next.wakeCnt = WCW'(WAKE_CYCLES);
                end
            end
            ST_WAKE: begin
                if (st_reg.sleepLvl) st_next.state = ST_SLEEP;
                else if (st_reg.wakeCnt == '0) st_next.state = ST_RUN;
                else st_next.wakeCnt = st_reg.wakeCnt - 1'b1;
            end
            ST_RUN: begin
                if (st_reg.sleepLvl) st_next.state = ST_SLEEP;
            end
            default: st_next.state = ST_SLEEP;
        endcase
        // ----------------------------------------
        // Conversion pipeline
        // ----------------------------------------
        if (st_reg.sleepLvl) begin
            st_next.pipeOk = '0;
            st_next.wordOk = 1'b0;
        end else begin
            st_next.pipe   = {st_reg.pipe[L-2:0], sampleCode};
            st_next.pipeOk = {st_reg.pipeOk[L-2:0], running};
            st_next.word   = fmtWord(st_reg.pipe[L-1], fmtTwos);
            st_next.wordOk = st_reg.pipeOk[L-1] && (st_reg.state == ST_RUN) && (st_reg.settleCnt == 3'h0);
        end
    end
    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_reg          <= '0;
            st_reg.sleepSync <= 3'h7;
            st_reg.sleepLvl <= 1'b1;
            st_reg.state    <= ST_SLEEP;
        end else begin
            st_reg <= st_next;
        end
    end
    // ----------------------------------------
    // Output buffer
    // ----------------------------------------
    adcc_fifo #(.WIDTH(DATA_W), .DEPTH(adcc_pkg::FIFO_DEPTH)) u_fifo (
        .mclk     (mclk),
        .rst      (rst),
        .flush    (st_reg.sleepLvl),
        .inValid  (st_reg.wordOk),
        .inReady  (fifoInReady),
        .inData   (st_reg.word),
        .outValid (fifoOutValid),
        .outReady (outReady),
        .outData  (fifoData)
    );
    // ----------------------------------------
    // Port outputs and status
    // ----------------------------------------
    assign outWord        = fifoOutValid ? fifoData : DATA_W'(adcc_pkg::RESET_WORD);
    assign outValid       = fifoOutValid && !st_reg.sleepLvl;
    assign inFifoReady    = fifoInReady;
    assign stabilizerOn   = selStab(st_reg.selLvl);
    assign twosComplement = fmtTwos;
    assign wakeSettling   = (st_reg.state == ST_WAKE);
endmodule

/* test/adcc_checker.sv */
// Port assertions for the converter control block
module adcc_checker #(
    parameter int DATA_W      = 14,
    parameter int WAKE_CYCLES = 10
) (
    // Clock and reset
    input wire logic              mclk,
    input wire logic              rst,
    // Inputs
    input wire logic              sleepRequest,
    input wire logic [1:0]        formatStabilizerSelect,
    input wire logic [DATA_W-1:0] sampleCode,
    input wire logic              outReady,
    // Outputs
    input wire logic [DATA_W-1:0] outWord,
    input wire logic              outValid,
    input wire logic              inFifoReady,
    input wire logic              stabilizerOn,
    input wire logic              twosComplement,
    input wire logic              wakeSettling
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence selSteady; $stable(formatStabilizerSelect)[*6]; endsequence
    sequence sleepHeld; sleepRequest[*6]; endsequence
    AST_SLEEP_IDLE: assert property (sleepHeld |-> !outValid) else $error("valid word while asleep");
    AST_SLEEP_WAIT: assert property (sleepHeld |-> !wakeSettling) else $error("wake wait while asleep");
    AST_STAB_DEC: assert property (selSteady |-> stabilizerOn == (formatStabilizerSelect < 2'h2))
        else $error("stabilizer decode wrong");
    AST_FMT_DEC: assert property (selSteady |-> twosComplement == (formatStabilizerSelect inside {2'h1, 2'h2}))
        else $error("format decode wrong");
    AST_WORD_HOLD: assert property (outValid && !outReady && !sleepRequest |=> outValid && $stable(outWord))
        else $error("word not held while stalled");
    AST_WAKE_EMPTY: assert property (wakeSettling |-> !outValid) else $error("word during wake wait");
    AST_WAKE_LEN: assert property ($rose(wakeSettling) |-> wakeSettling[*8]) else $error("wake wait short");
    AST_FULL_VALID: assert property (!inFifoReady && !sleepRequest |-> outValid) else $error("full but idle");
endmodule
bind adcc_top adcc_checker #(.DATA_W(DATA_W), .WAKE_CYCLES(WAKE_CYCLES)) chk (.*);

/* test/adcc_receiver.sv */
// Receiving logic model capturing output words
module adcc_receiver (
    // Clock and control
    input wire logic        mclk,
    input wire logic        stall,
    // Output port of the block
    input wire logic [13:0] outWord,
    input wire logic        outValid,
    output logic            outReady
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [13:0] words[$];
    logic        readyReg = 1'b0;
    assign outReady = readyReg;
    always @(posedge mclk) readyReg <= !stall;
    always @(posedge mclk) if (outValid && outReady) words.push_back(outWord);
endmodule

/* test/test_adcc_top.sv */
// Self-checking bench for the converter control block
module test_adcc_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst, sleepRequest, outValid, outReady, inFifoReady, stabilizerOn, twosComplement, wakeSettling, stall;
    logic [1:0] formatStabilizerSelect;
    logic [13:0] sampleCode, outWord;
    int errors = 0, cmp_count = 0, cycles = 0;
    adcc_top #(.DATA_W(14), .WAKE_CYCLES(10)) dut (.mclk(mclk), .rst(rst), .sleepRequest(sleepRequest),
        .formatStabilizerSelect(formatStabilizerSelect), .sampleCode(sampleCode), .outWord(outWord),
        .outValid(outValid), .outReady(outReady), .inFifoReady(inFifoReady), .stabilizerOn(stabilizerOn),
        .twosComplement(twosComplement), .wakeSettling(wakeSettling));
    adcc_receiver rx (.mclk(mclk), .stall(stall), .outWord(outWord), .outValid(outValid), .outReady(outReady));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            summarize();
        end
    end
    task automatic check(string name, logic [13:0] seen, logic [13:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic selScan();
        logic [13:0] code;
        for (int s = 0; s < 4; s++) begin
            formatStabilizerSelect = 2'(s);
            tick(10);
            check("stab", 14'(stabilizerOn), 14'(s < 2));
            check("twos", 14'(twosComplement), 14'(s == 1 || s == 2));
            for (int j = 0; j < 2; j++) begin
                code = j ? 14'h3fff : 14'h2000;
                sampleCode = code;
                tick(14);
                rx.words.delete();
                tick(3);
                check("count", 14'(rx.words.size()), 14'h3);
                check("word", rx.words[0], code ^ {(s == 1 || s == 2), 13'h0});
            end
        end
    endtask
    task automatic latency();
        int n;
        tick(14);
        sampleCode = 14'h1234;
        rx.words.delete();
        for (n = 0; n < 20 && (rx.words.size() == 0 || rx.words[$] !== 14'h1234); n++)
            tick(1);
        check("lat", 14'(n), 14'(adcc_pkg::LATENCY + 3));
    endtask
    task automatic fillDrain();
        stall = 1'b1;
        for (int i = 0; i < 50; i++) begin
            sampleCode = 14'(i);
            tick(1);
        end
        check("full", 14'({inFifoReady, outValid}), 14'h1);
        rx.words.delete();
        stall = 1'b0;
        tick(40);
        check("ramp", rx.words[31], rx.words[30] + 14'h1);
    endtask
    task automatic sleepCycle();
        sleepRequest = 1'b1;
        tick(8);
        check("sleep", 14'(outValid), 14'h0);
        rx.words.delete();
        sleepRequest = 1'b0;
        tick(6);
        check("wake", 14'(wakeSettling), 14'h1);
        check("lost", 14'(rx.words.size()), 14'h0);
        tick(30);
        check("resume", rx.words[$], sampleCode);
    endtask
    task automatic midReset();
        rst = 1'b1;
        tick(2);
        check("rstValid", 14'(outValid), 14'h0);
        check("rstWord", outWord, adcc_pkg::RESET_WORD);
        check("rstStatus", 14'({stabilizerOn, twosComplement, wakeSettling}), 14'h4);
        rst = 1'b0;
        tick(30);
        check("rstResume", 14'(outValid), 14'h1);
        check("rstData", rx.words[$], sampleCode);
    endtask
    initial begin
        {rst, sleepRequest, stall} = 3'b100;
        formatStabilizerSelect = 2'h0;
        sampleCode = 14'h0000;
        tick(4);
        rst = 1'b0;
        tick(30);
        selScan();
        latency();
        fillDrain();
        sleepCycle();
        midReset();
        summarize();
    end
endmodule
